// File: design/pm_pkg.sv
// shared constants and types for the switch port power management block
package pm_pkg;
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned NUM_DS = NUM_PORTS - 1;
  localparam int unsigned NUM_BUDGET = 8;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BIDX_W = 3;

  // power state field encodings
  localparam logic [1:0] PS_FULL = 2'h0;
  localparam logic [1:0] PS_HOT = 2'h3;
  localparam logic [DATA_W-1:0] BUDGET_HDR_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BUDGET_DV_RST = 32'h0000_0000;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

  typedef enum logic [1:0] {
    D0_UNINIT,
    D0_ACTIVE,
    D3_HOT,
    D3_COLD
  } pm_state_t;

  // request classes seen at a bridge
  typedef enum logic [2:0] {
    REQ_CFG0,
    REQ_MSG_OWN,
    REQ_OTHER,
    REQ_CPL_OWN,
    REQ_CPL_PASS
  } req_class_t;

  typedef enum logic [1:0] {
    DISP_ACCEPT,
    DISP_UR,
    DISP_UC,
    DISP_ROUTE
  } disp_t;
endpackage

// File: design/pm_port_fsm.sv
// per port device power state machine
`timescale 1ns/100ps
`default_nettype none
module pm_port_fsm
  import pm_pkg::*;
(
  input wire logic sys_clk_i,   // core clock
  input wire logic srst_i,      // fundamental reset
  input wire logic cfg_done_i,  // bridge configured by software
  input wire logic ps_wr_i,     // power state field write strobe
  input wire logic [1:0] ps_val_i, // written encoding
  input wire logic pwr_off_i,   // power removed
  output var pm_state_t state_o // current state
);
  pm_state_t state_q;
  assign state_o = state_q;

  // context is never cleared on leaving hot; only reset touches it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q <= D0_UNINIT;
    end else begin
      case (state_q)
        D0_UNINIT: if (cfg_done_i) state_q <= D0_ACTIVE;
        D0_ACTIVE: if (ps_wr_i && ps_val_i == PS_HOT) begin
          state_q <= D3_HOT;
        end
        D3_HOT: begin
          if (pwr_off_i) begin
            state_q <= D3_COLD;
          end else if (ps_wr_i && ps_val_i == PS_FULL) begin
            state_q <= D0_UNINIT;
          end
        end
        D3_COLD: state_q <= D3_COLD;
        default: state_q <= D0_UNINIT;
      endcase
    end
  end

  chk_hot_to_uninit: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state_q == D3_HOT && ps_wr_i && ps_val_i == PS_FULL && !pwr_off_i
    |=> state_q == D0_UNINIT)
    else $error("hot did not return to uninitialized");
  chk_active_to_hot: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state_q == D0_ACTIVE && ps_wr_i && ps_val_i == PS_HOT
    |=> state_q == D3_HOT)
    else $error("active did not enter hot");
  chk_uninit_to_active: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state_q == D0_UNINIT && cfg_done_i |=> state_q == D0_ACTIVE)
    else $error("configured port did not become active");
  chk_hot_to_cold: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state_q == D3_HOT && pwr_off_i |=> state_q == D3_COLD)
    else $error("power loss in hot did not give cold");
endmodule
`default_nettype wire

// File: design/pm_ds_timer.sv
// down counter that flags expiry of a programmed timeout
`timescale 1ns/100ps
`default_nettype none
module pm_ds_timer
  import pm_pkg::*;
(
  input wire logic sys_clk_i,   // core clock
  input wire logic srst_i,      // reset
  input wire logic start_i,     // load and run
  input wire logic stop_i,      // halt
  input wire logic [TMR_W-1:0] limit_i, // timeout in cycles
  output logic expire_o         // one cycle pulse at timeout
);
  logic [TMR_W-1:0] cnt_q;
  logic run_q;
  logic expire_q;
  assign expire_o = expire_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      run_q <= 1'b0;
      cnt_q <= TMR_ZERO;
      expire_q <= 1'b0;
    end else if (start_i) begin
      // a fresh start beats a clear, so a new event keeps its timer
      run_q <= 1'b1;
      cnt_q <= limit_i;
      expire_q <= 1'b0;
    end else if (stop_i) begin
      run_q <= 1'b0;
      cnt_q <= TMR_ZERO;
      expire_q <= 1'b0;
    end else if (run_q) begin
      expire_q <= (cnt_q <= TMR_ONE);
      run_q <= (cnt_q > TMR_ONE);
      cnt_q <= cnt_q - TMR_ONE;
    end else begin
      expire_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: design/pm_switch.sv
// power management top: port states, event resend, turn-off fence, budget
`timescale 1ns/100ps
`default_nettype none
module pm_switch
  import pm_pkg::*;
(
  input wire logic sys_clk_i,                 // core clock
  input wire logic srst_i,                    // fundamental reset
  input wire logic [NUM_PORTS-1:0] cfg_done_i, // bridge configured
  input wire logic [NUM_PORTS-1:0] ps_wr_i,    // power state write
  input wire logic [1:0] ps_val_i,            // written encoding
  input wire logic pwr_off_i,                 // device power removed
  output logic [2*NUM_PORTS-1:0] state_o,     // packed port states
  output logic dev_low_power_o,               // whole device low power
  output logic [NUM_DS-1:0] link_l1_ok_o,     // link may enter L1
  input wire logic req_vld_i,                 // request at a bridge
  input wire logic [BIDX_W-1:0] req_port_i,   // target port
  input wire logic req_sec_i,                 // arrived on secondary
  input wire logic [2:0] req_class_i,         // request class
  output logic [1:0] req_disp_o,              // disposition
  output logic req_disp_vld_o,                // disposition valid
  input wire logic err_vld_i,                 // error event
  input wire logic err_from_tlp_i,            // error caused by a packet
  input wire logic [BIDX_W-1:0] err_port_i,   // port of error
  output logic err_msg_o,                     // error message sent
  input wire logic [NUM_DS-1:0] hp_event_i,   // hot-plug event
  input wire logic [NUM_DS-1:0] pme_clr_i,    // event status clear
  input wire logic [TMR_W-1:0] svc_tmo_i,     // service timeout
  output logic [NUM_DS-1:0] pme_msg_o,        // event message pulse
  output logic [NUM_DS-1:0] pme_sts_o,        // event status bits
  input wire logic turnoff_i,                 // turn-off from upstream
  input wire logic [NUM_DS-1:0] ds_active_i,  // downstream link active
  input wire logic [NUM_DS-1:0] ds_ack_i,     // downstream ack received
  input wire logic [TMR_W-1:0] ack_tmo_i,     // ack timeout
  output logic [NUM_DS-1:0] ds_turnoff_o,     // forwarded turn-off
  output logic [NUM_DS-1:0] ds_l23_o,         // link to L2/L3 ready
  output logic [NUM_DS-1:0] ds_tmo_o,         // ack timeout declared
  output logic us_ack_o,                      // ack sent upstream
  output logic us_l23_o,                      // upstream L2/L3 ready
  input wire logic budget_unlock_i,           // data unlock bit
  input wire logic hdr_load_i,                // external header load
  input wire logic [DATA_W-1:0] hdr_data_i,   // header load value
  input wire logic bdv_wr_i,                  // data value write
  input wire logic bdv_ext_i,                 // external init write
  input wire logic [BIDX_W-1:0] bdv_idx_i,    // data value index
  input wire logic [DATA_W-1:0] bdv_data_i,   // write data
  output logic [DATA_W-1:0] bdv_rdata_o,      // read data
  output logic [DATA_W-1:0] budget_hdr_o      // capability header
);
  pm_state_t st [NUM_PORTS];
  logic [NUM_DS-1:0] svc_exp;
  logic [NUM_DS-1:0] ack_exp;
  logic [NUM_DS-1:0] pme_send;
  logic [NUM_DS-1:0] fence_done;
  logic [2*NUM_PORTS-1:0] state_q;
  logic dev_low_q;
  logic [NUM_DS-1:0] l1_ok_q;
  logic [1:0] disp_q;
  logic disp_vld_q;
  logic err_msg_q;
  logic [NUM_DS-1:0] pme_msg_q;
  logic [NUM_DS-1:0] pme_sts_q;
  logic [NUM_DS-1:0] got_ack_q;
  logic [NUM_DS-1:0] ds_to_q;
  logic [NUM_DS-1:0] ds_l23_q;
  logic [NUM_DS-1:0] ds_tmo_q;
  logic fence_q;
  logic us_ack_q;
  logic us_l23_q;
  logic [DATA_W-1:0] hdr_q;
  logic [DATA_W-1:0] bdv_q [NUM_BUDGET];
  logic [DATA_W-1:0] rdata_q;

  // classify one request against its bridge state
  function automatic disp_t classify(pm_state_t s, logic sec,
                                     logic [2:0] c);
    disp_t d;
    d = (c == REQ_CPL_PASS) ? DISP_ROUTE : DISP_ACCEPT;
    if (s == D3_HOT) begin
      if (c == REQ_CPL_PASS) d = DISP_ROUTE;
      else if (c == REQ_CPL_OWN) d = DISP_UC;
      else if (sec) d = DISP_UR;
      else if (c == REQ_CFG0 || c == REQ_MSG_OWN) d = DISP_ACCEPT;
      else d = DISP_UR;
    end
    return d;
  endfunction

  function automatic logic is_hot(pm_state_t s);
    return s == D3_HOT;
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      // each bridge owns its state; port 0 stands for the device
      pm_port_fsm u_fsm (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .cfg_done_i(cfg_done_i[gp]),
        .ps_wr_i(ps_wr_i[gp]),
        .ps_val_i(ps_val_i),
        .pwr_off_i(pwr_off_i),
        .state_o(st[gp])
      );
    end
    for (gp = 0; gp < NUM_DS; gp++) begin : g_ds
      pm_ds_timer u_svc (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .start_i(pme_send[gp]),
        .stop_i(pme_clr_i[gp]),
        .limit_i(svc_tmo_i),
        .expire_o(svc_exp[gp])
      );
      pm_ds_timer u_ack (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .start_i(ds_to_q[gp]),
        .stop_i(ds_ack_i[gp] || !fence_q),
        .limit_i(ack_tmo_i),
        .expire_o(ack_exp[gp])
      );
      // no events from cold; resend while status stays set
      assign pme_send[gp] = st[gp+1] != D3_COLD &&
        ((hp_event_i[gp] && !pme_sts_q[gp]) ||
         (svc_exp[gp] && pme_sts_q[gp] && !pme_clr_i[gp]));
      assign fence_done[gp] = got_ack_q[gp] || !ds_active_i[gp];
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q <= '0;
      dev_low_q <= 1'b0;
      l1_ok_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        state_q[2*i +: 2] <= st[i];
      end
      for (int i = 0; i < NUM_DS; i++) begin
        l1_ok_q[i] <= is_hot(st[i+1]);
      end
      // the upstream ack is a pulse; the ready level keeps this standing
      dev_low_q <= is_hot(st[0]) && us_l23_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      disp_q <= DISP_ACCEPT;
      disp_vld_q <= 1'b0;
      err_msg_q <= 1'b0;
    end else begin
      disp_vld_q <= req_vld_i;
      disp_q <= classify(st[req_port_i], req_sec_i, req_class_i);
      // non-packet errors are dropped while the bridge is hot
      err_msg_q <= err_vld_i &&
        (err_from_tlp_i || !is_hot(st[err_port_i]));
    end
  end

  // event status: a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pme_sts_q <= '0;
      pme_msg_q <= '0;
    end else begin
      pme_msg_q <= pme_send;
      pme_sts_q <= (pme_sts_q & ~pme_clr_i) | pme_send;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fence_q <= 1'b0;
      ds_to_q <= '0;
      got_ack_q <= '0;
      ds_l23_q <= '0;
      ds_tmo_q <= '0;
      us_ack_q <= 1'b0;
      us_l23_q <= 1'b0;
    end else begin
      ds_to_q <= '0;
      us_ack_q <= 1'b0;
      if (turnoff_i && !fence_q) begin
        fence_q <= 1'b1;
        ds_to_q <= ds_active_i;
        got_ack_q <= '0;
        ds_l23_q <= '0;
        ds_tmo_q <= '0;
      end else if (fence_q) begin
        got_ack_q <= got_ack_q | ds_ack_i | ack_exp;
        ds_tmo_q <= ds_tmo_q | (ack_exp & ~got_ack_q);
        ds_l23_q <= ds_l23_q | ds_ack_i | ack_exp;
        if (&fence_done) begin
          fence_q <= 1'b0;
          us_ack_q <= 1'b1;
          us_l23_q <= 1'b1;
        end
      end
      // return to uninitialized reopens the upstream link
      if (st[0] == D0_UNINIT) us_l23_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hdr_q <= BUDGET_HDR_RST;
    end else if (hdr_load_i) begin
      hdr_q <= hdr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_BUDGET; i++) begin
        bdv_q[i] <= BUDGET_DV_RST;
      end
      rdata_q <= BUDGET_DV_RST;
    end else begin
      if (bdv_ext_i || (bdv_wr_i && budget_unlock_i)) begin
        bdv_q[bdv_idx_i] <= bdv_data_i;
      end
      rdata_q <= bdv_q[bdv_idx_i];
    end
  end

  assign state_o = state_q;
  assign dev_low_power_o = dev_low_q;
  assign link_l1_ok_o = l1_ok_q;
  assign req_disp_o = disp_q;
  assign req_disp_vld_o = disp_vld_q;
  assign err_msg_o = err_msg_q;
  assign pme_msg_o = pme_msg_q;
  assign pme_sts_o = pme_sts_q;
  assign ds_turnoff_o = ds_to_q;
  assign ds_l23_o = ds_l23_q;
  assign ds_tmo_o = ds_tmo_q;
  assign us_ack_o = us_ack_q;
  assign us_l23_o = us_l23_q;
  assign bdv_rdata_o = rdata_q;
  assign budget_hdr_o = hdr_q;

  sequence s_turnoff;
    turnoff_i && !fence_q;
  endsequence
  sequence s_fwd;
    ds_turnoff_o == $past(ds_active_i);
  endsequence
  sequence s_fence_close;
    fence_q && (&fence_done);
  endsequence

  chk_turnoff_fwd: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    s_turnoff |=> s_fwd)
    else $error("turn-off not forwarded to active ports");
  chk_ack_after_all: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    us_ack_o |-> $past(fence_q) && $past(&fence_done))
    else $error("upstream ack before all downstream acks");
  chk_fence_close: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    s_fence_close |=> us_ack_o)
    else $error("fence closed without upstream ack");
  chk_tmo_as_ack: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    fence_q && ack_exp != '0
    |=> (got_ack_q & ds_l23_q & $past(ack_exp)) == $past(ack_exp))
    else $error("ack timeout not treated as ack");
  chk_no_pme_cold: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    st[2] == D3_COLD |=> !pme_msg_o[1])
    else $error("event message from cold state");
  chk_pme_first: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    hp_event_i[0] && !pme_sts_q[0] && st[1] != D3_COLD
    |=> pme_msg_o[0] && pme_sts_o[0])
    else $error("hot-plug event message not sent");
  chk_pme_resend: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    svc_exp[0] && pme_sts_q[0] && !pme_clr_i[0] && st[1] != D3_COLD
    |=> pme_msg_o[0])
    else $error("event message not resent on timeout");
  chk_us_l23_clear: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    st[0] == D0_UNINIT |=> !us_l23_o)
    else $error("upstream link not reopened in uninitialized");
  chk_hot_ur: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    req_vld_i && st[req_port_i] == D3_HOT && req_sec_i
    && req_class_i == REQ_OTHER |=> req_disp_o == DISP_UR)
    else $error("secondary request in hot not unsupported");
  chk_primary_ur: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    req_vld_i && st[req_port_i] == D3_HOT && !req_sec_i
    && req_class_i == REQ_OTHER |=> req_disp_o == DISP_UR)
    else $error("primary request in hot not unsupported");
  chk_cfg_accept: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    req_vld_i && st[req_port_i] == D3_HOT && !req_sec_i
    && (req_class_i == REQ_CFG0 || req_class_i == REQ_MSG_OWN)
    |=> req_disp_o == DISP_ACCEPT)
    else $error("config or own message refused in hot");
  chk_disp_pulse: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    req_vld_i |=> req_disp_vld_o)
    else $error("request not answered");
  chk_own_cpl_uc: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    req_vld_i && st[req_port_i] == D3_HOT && req_class_i == REQ_CPL_OWN
    |=> req_disp_o == DISP_UC)
    else $error("own completion in hot not unexpected");
  chk_pass_routed: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    req_vld_i && req_class_i == REQ_CPL_PASS |=> req_disp_o == DISP_ROUTE)
    else $error("passing completion not routed");
  chk_err_drop: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    err_vld_i && !err_from_tlp_i && st[err_port_i] == D3_HOT
    |=> !err_msg_o)
    else $error("non-packet error reported in hot");
  chk_tlp_err_kept: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    err_vld_i && err_from_tlp_i |=> err_msg_o)
    else $error("packet error not reported");
  chk_l1_hot: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    st[1] == D3_HOT |=> link_l1_ok_o[0])
    else $error("hot bridge did not allow its link to idle");
  chk_dev_low: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    st[0] == D3_HOT && us_l23_q |=> dev_low_power_o)
    else $error("device not low power after upstream ack");
  chk_hdr_held: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !hdr_load_i |=> $stable(budget_hdr_o))
    else $error("budget header changed without a load");
  chk_budget_lock: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    bdv_wr_i && !bdv_ext_i && !budget_unlock_i
    |=> bdv_q[$past(bdv_idx_i)] == $past(bdv_q[bdv_idx_i]))
    else $error("locked budget data was written");
  chk_budget_unlock: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    bdv_wr_i && budget_unlock_i
    |=> bdv_q[$past(bdv_idx_i)] == $past(bdv_data_i))
    else $error("unlocked budget write was lost");
endmodule
`default_nettype wire

// File: tb/pm_link_partner.sv
// downstream link partners that answer forwarded turn-off messages
`timescale 1ns/100ps
`default_nettype none
module pm_link_partner
  import pm_pkg::*;
(
  input wire logic sys_clk_i,           // core clock
  input wire logic srst_i,              // reset
  input wire logic [NUM_DS-1:0] toff_i, // forwarded turn-off
  input wire logic [NUM_DS-1:0] mute_i, // partners that never answer
  output logic [NUM_DS-1:0] ack_o       // ack pulse
);
  int cnt [NUM_DS];

  // each partner answers after its own delay, so acks arrive staggered
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < NUM_DS; i++) begin
      ack_o[i] <= 1'b0;
      if (srst_i) begin
        cnt[i] <= 0;
      end else if (toff_i[i]) begin
        cnt[i] <= 2 * i + 3;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        ack_o[i] <= (cnt[i] == 1) && !mute_i[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_pm_switch.sv
// self-checking bench for the port power management block
`timescale 1ns/100ps
`default_nettype none
module tb_pm_switch
  import pm_pkg::*;
;
  localparam int SVC = 20;
  localparam int ATO = 30;
  logic sys_clk_i, srst_i, pwr_off_i, req_vld_i, req_sec_i, err_vld_i;
  logic err_from_tlp_i, turnoff_i, budget_unlock_i, hdr_load_i;
  logic bdv_wr_i, bdv_ext_i, dev_low_power_o, req_disp_vld_o, err_msg_o;
  logic us_ack_o, us_l23_o;
  logic [7:0] cfg_done_i, ps_wr_i;
  logic [1:0] ps_val_i, req_disp_o;
  logic [2:0] req_port_i, req_class_i, err_port_i, bdv_idx_i;
  logic [6:0] hp_event_i, pme_clr_i, ds_active_i, ds_ack_i, mute;
  logic [6:0] link_l1_ok_o, pme_msg_o, pme_sts_o, ds_turnoff_o;
  logic [6:0] ds_l23_o, ds_tmo_o;
  logic [15:0] svc_tmo_i, ack_tmo_i, state_o;
  logic [31:0] hdr_data_i, bdv_data_i, bdv_rdata_o, budget_hdr_o;
  int st [8];
  int bm [8];
  int mismatches, comparisons, n;
  int seed = 32'h30efb895;

  pm_switch u_pm_switch (
    .sys_clk_i, .srst_i, .cfg_done_i, .ps_wr_i, .ps_val_i, .pwr_off_i,
    .state_o, .dev_low_power_o, .link_l1_ok_o, .req_vld_i, .req_port_i,
    .req_sec_i, .req_class_i, .req_disp_o, .req_disp_vld_o, .err_vld_i,
    .err_from_tlp_i, .err_port_i, .err_msg_o, .hp_event_i, .pme_clr_i,
    .svc_tmo_i, .pme_msg_o, .pme_sts_o, .turnoff_i, .ds_active_i,
    .ds_ack_i, .ack_tmo_i, .ds_turnoff_o, .ds_l23_o, .ds_tmo_o, .us_ack_o,
    .us_l23_o, .budget_unlock_i, .hdr_load_i, .hdr_data_i, .bdv_wr_i,
    .bdv_ext_i, .bdv_idx_i, .bdv_data_i, .bdv_rdata_o, .budget_hdr_o
  );

  pm_link_partner u_pm_link_partner (
    .sys_clk_i, .srst_i, .toff_i(ds_turnoff_o), .mute_i(mute),
    .ack_o(ds_ack_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic chk_st();
    logic [15:0] e;
    for (int i = 0; i < 8; i++) e[2*i+:2] = st[i][1:0];
    chk(state_o, e);
  endtask

  task automatic set_cfg(input logic [7:0] m);
    cfg_done_i = m;
    for (int i = 0; i < 8; i++) if (m[i] && st[i] == 0) st[i] = 1;
    tick(3);
  endtask

  // illegal writes are silently dropped, so the model only moves on legal ones
  task automatic set_ps(input logic [7:0] m, input logic [1:0] v);
    ps_wr_i = m;
    ps_val_i = v;
    tick(1);
    ps_wr_i = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && st[i] == 1 && v == PS_HOT) st[i] = 2;
      else if (m[i] && st[i] == 2 && v == PS_FULL) st[i] = cfg_done_i[i];
    end
    tick(3);
  endtask

  function automatic int disp_hot(input int s, input int c);
    if (s != 0 && c < 3) return 1;
    if (c < 2) return 0;
    return c - 1;
  endfunction

  task automatic rd_all();
    for (int i = 0; i < 8; i++) begin
      bdv_idx_i = i[2:0];
      tick(2);
      chk(bdv_rdata_o, bm[i]);
    end
  endtask

  task automatic pme_pulse(input logic [6:0] m);
    hp_event_i = m;
    tick(1);
    hp_event_i = 7'h00;
  endtask

  initial begin
    {srst_i, pwr_off_i, req_vld_i, req_sec_i, err_vld_i} = 5'h10;
    {err_from_tlp_i, turnoff_i, budget_unlock_i, hdr_load_i} = 4'h0;
    {bdv_wr_i, bdv_ext_i, cfg_done_i, ps_wr_i, ps_val_i} = 20'h00000;
    {req_port_i, req_class_i, err_port_i, bdv_idx_i} = 12'h000;
    {hp_event_i, pme_clr_i, ds_active_i, mute} = 28'h0000000;
    svc_tmo_i = 16'(SVC);
    ack_tmo_i = 16'(ATO);
    hdr_data_i = 32'h00000000;
    bdv_data_i = 32'h00000000;
    tick(16);
    srst_i = 1'b0;
    tick(2);
    chk_st();
    chk(budget_hdr_o, BUDGET_HDR_RST);
    done("reset");
    hdr_data_i = $random(seed);
    hdr_load_i = 1'b1;
    tick(1);
    hdr_load_i = 1'b0;
    tick(1);
    chk(budget_hdr_o, hdr_data_i);
    // odd indices unlocked, index 4 is an external load while locked
    for (int i = 0; i < 8; i++) begin
      budget_unlock_i = i[0];
      bdv_ext_i = (i == 4);
      bdv_wr_i = (i != 4);
      bdv_idx_i = i[2:0];
      bdv_data_i = $random(seed);
      if (i[0] || i == 4) bm[i] = bdv_data_i;
      tick(1);
      {bdv_wr_i, bdv_ext_i} = 2'h0;
    end
    rd_all();
    done("budget");
    set_cfg(8'hff);
    chk_st();
    set_ps(8'h03, PS_HOT);
    chk_st();
    chk(link_l1_ok_o, 7'h01);
    done("states");
    req_port_i = 3'h1;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 5; c++) begin
        req_vld_i = 1'b1;
        req_sec_i = s[0];
        req_class_i = c[2:0];
        tick(1);
        req_vld_i = 1'b0;
        chk(req_disp_vld_o, 1);
        chk(req_disp_o, disp_hot(s, c));
        tick(1);
      end
    end
    err_port_i = 3'h1;
    for (int t = 0; t < 2; t++) begin
      err_vld_i = 1'b1;
      err_from_tlp_i = t[0];
      tick(1);
      err_vld_i = 1'b0;
      chk(err_msg_o, t);
      tick(2);
    end
    done("hot requests");
    pme_pulse(7'h01);
    chk(pme_msg_o, 7'h01);
    chk(pme_sts_o, 7'h01);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (!pme_msg_o[0] && n < 200);
    chk(n, SVC + 1);
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
    pme_clr_i = 7'h01;
    tick(1);
    pme_clr_i = 7'h00;
    tick(1);
    chk(pme_sts_o, 7'h00);
    done("event resend");
    // the muted partner forces the ack timeout path
    ds_active_i = 7'h0f;
    mute = 7'h08;
    turnoff_i = 1'b1;
    tick(1);
    turnoff_i = 1'b0;
    chk(ds_turnoff_o, 7'h0f);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (!us_ack_o && n < 100);
    // a fence that never closes must not end in a clean verdict
    if (n >= 100) begin
      mismatches++;
      print_verdict();
    end
    chk(n > ATO, 1);
    chk(ds_tmo_o, 7'h08);
    chk(ds_l23_o[3], 1);
    tick(2);
    chk(us_l23_o, 1);
    chk(dev_low_power_o, 1);
    done("fence");
    cfg_done_i = 8'h00;
    set_ps(8'h03, PS_FULL);
    chk_st();
    chk(us_l23_o, 0);
    pme_pulse(7'h01);
    chk(pme_msg_o, 7'h01);
    pme_clr_i = 7'h01;
    tick(1);
    pme_clr_i = 7'h00;
    rd_all();
    done("resume");
    set_cfg(8'hff);
    set_ps(8'h04, PS_HOT);
    pwr_off_i = 1'b1;
    st[2] = 3;
    tick(3);
    chk_st();
    pme_pulse(7'h02);
    chk(pme_msg_o, 7'h00);
    done("cold");
    {cfg_done_i, pwr_off_i, srst_i} = 10'h001;
    tick(2);
    srst_i = 1'b0;
    for (int i = 0; i < 8; i++) st[i] = 0;
    tick(2);
    chk_st();
    done("second reset");
    print_verdict();
  end
endmodule
`default_nettype wire
